// ===== hw/aer_regs.sv
// Error reporting register bank: correctable, header log and PCI side status
`timescale 1ns/100ps
`include "aer_regs_consts.svh"

// Function
// - Retransmit timer expiry sets correctable bit 12
// - Retransmit count wrap sets correctable bit 8
// - Symbol error in link packet sets 7
// - Symbol error in transaction packet sets 6
// - Any symbol error sets correctable bit 0
// - Status bits clear only on written one
// - Masked condition sets nothing, logs nothing
// - Mask bits 12,8,7,6,0 read-write, reset zero
// - Control bit 8 enables CRC checking
// - Control bit 6 enables CRC generation
// - Bits 7 and 5 read one always
// - First error pointer loads first position
// - Latest error header into four words
// - Earliest header byte in low byte
// - Secondary system error sets bit 12
// - Secondary parity error sets bit 11
// - Discard timer expiry sets bit 10
// - Upstream address parity error sets 9
// - Upstream data parity error sets 7
// - Master abort bit 3, target abort 2
// - Reserved bits read zero, ignore writes
// - All fields reset on any reset source
module aer_regs
  import aer_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic globalResetPin,
  input wire logic fundamentalReset,
  input wire aer_cfg_req_s cfgReq,
  output logic [31:0] cfgRdata,
  output logic cfgRdValid,
  input wire aer_cor_evt_s corEvt,
  input wire aer_sec_evt_s secEvt,
  input wire aer_hdr_cap_s hdrCap,
  output logic corErrMsg,
  output logic e2eCrcCheckEnable,
  output logic e2eCrcGenerateEnable
);

  // ----------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------
  // Pin levels come from outside; two stages before use
  logic [1:0] grstSync_r;
  logic [1:0] frstSync_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      grstSync_r <= 2'h0;
      frstSync_r <= 2'h0;
    end else begin
      grstSync_r <= {grstSync_r[0], globalResetPin};
      frstSync_r <= {frstSync_r[0], fundamentalReset};
    end
  end
  logic softRst;
  assign softRst = grstSync_r[1] | frstSync_r[1];

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] corSts_r;
  logic [31:0] corMsk_r;
  logic [31:0] secSts_r;
  logic chkEn_r;
  logic genEn_r;
  logic [4:0] firstErr_r;
  logic ptrLoaded_r;
  logic [31:0] hdrLog_r [4];

  logic wrCorSts;
  logic wrCorMsk;
  logic wrCapCtl;
  logic wrSecSts;
  assign wrCorSts = cfgReq.wr && (cfgReq.addr == `AER_OFF_COR_STS);
  assign wrCorMsk = cfgReq.wr && (cfgReq.addr == `AER_OFF_COR_MSK);
  assign wrCapCtl = cfgReq.wr && (cfgReq.addr == `AER_OFF_CAP_CTL);
  assign wrSecSts = cfgReq.wr && (cfgReq.addr == `AER_OFF_SEC_STS);

  // ----------------------------------------------------------------
  // Correctable status
  // ----------------------------------------------------------------
  logic [31:0] corRaw;
  logic [31:0] corSet;
  always_comb begin
    corRaw = `AER_ZERO_RST;
    corRaw[`AER_COR_BIT_TMOUT] = corEvt.retransmitTimerExpired;
    corRaw[`AER_COR_BIT_ROLL] = corEvt.retransmitCountWrap;
    corRaw[`AER_COR_BIT_BADLNK] = corEvt.linkPacketSymbolErr;
    corRaw[`AER_COR_BIT_BADTLP] = corEvt.transactionPacketSymbolErr;
    corRaw[`AER_COR_BIT_RXERR] = corEvt.anySymbolErr;
  end
  assign corSet = corRaw & ~corMsk_r & `AER_COR_IMPL;

  // Set beats clear in the same cycle so no event is lost
  logic [31:0] corClr;
  assign corClr = wrCorSts ? cfgReq.wdata : `AER_ZERO_RST;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      corSts_r <= `AER_ZERO_RST;
    end else if (softRst) begin
      corSts_r <= `AER_ZERO_RST;
    end else begin
      corSts_r <= ((corSts_r & ~corClr) | corSet) & `AER_COR_IMPL;
    end
  end

  // Message for each cycle with an unmasked condition, whether or not its status bit is already set
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      corErrMsg <= 1'b0;
    end else begin
      corErrMsg <= !softRst && (|corSet);
    end
  end

  // ----------------------------------------------------------------
  // Correctable mask
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      corMsk_r <= `AER_ZERO_RST;
    end else if (softRst) begin
      corMsk_r <= `AER_ZERO_RST;
    end else if (wrCorMsk) begin
      corMsk_r <= cfgReq.wdata & `AER_COR_IMPL;
    end
  end

  // ----------------------------------------------------------------
  // Capabilities and control
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chkEn_r <= 1'b0;
      genEn_r <= 1'b0;
    end else if (softRst) begin
      chkEn_r <= 1'b0;
      genEn_r <= 1'b0;
    end else if (wrCapCtl) begin
      chkEn_r <= cfgReq.wdata[`AER_CTL_BIT_CHKEN];
      genEn_r <= cfgReq.wdata[`AER_CTL_BIT_GENEN];
    end
  end

  // Enables go out registered so the datapath sees a clean level
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      e2eCrcCheckEnable <= 1'b0;
      e2eCrcGenerateEnable <= 1'b0;
    end else begin
      e2eCrcCheckEnable <= chkEn_r && !softRst;
      e2eCrcGenerateEnable <= genEn_r && !softRst;
    end
  end

  // First pointer holds until reset; later errors do not move it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      firstErr_r <= `AER_PTR_RST;
      ptrLoaded_r <= 1'b0;
    end else if (softRst) begin
      firstErr_r <= `AER_PTR_RST;
      ptrLoaded_r <= 1'b0;
    end else if (hdrCap.valid && !ptrLoaded_r) begin
      firstErr_r <= hdrCap.statusBit;
      ptrLoaded_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Header log
  // ----------------------------------------------------------------
  // Header arrives byte 0 first in header[127:120]; swap into low lanes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        hdrLog_r[i] <= `AER_ZERO_RST;
      end
    end else if (softRst) begin
      for (int i = 0; i < 4; i++) begin
        hdrLog_r[i] <= `AER_ZERO_RST;
      end
    end else if (hdrCap.valid) begin
      for (int i = 0; i < 4; i++) begin
        hdrLog_r[i] <= {hdrCap.header[96-32*i +: 8], hdrCap.header[104-32*i +: 8],
                        hdrCap.header[112-32*i +: 8], hdrCap.header[120-32*i +: 8]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Secondary bus status
  // ----------------------------------------------------------------
  logic [31:0] secSet;
  always_comb begin
    secSet = `AER_ZERO_RST;
    secSet[12] = secEvt.pciSystemErrSeen;
    secSet[11] = secEvt.pciParityErrSeen;
    secSet[10] = secEvt.discardTimerExpired;
    secSet[9] = secEvt.upstreamAddrParityErr;
    secSet[7] = secEvt.upstreamDataParityErr;
    secSet[3] = secEvt.masterAbortRcvd;
    secSet[2] = secEvt.targetAbortRcvd;
  end

  logic [31:0] secClr;
  assign secClr = wrSecSts ? cfgReq.wdata : `AER_ZERO_RST;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      secSts_r <= `AER_ZERO_RST;
    end else if (softRst) begin
      secSts_r <= `AER_ZERO_RST;
    end else begin
      secSts_r <= ((secSts_r & ~secClr) | secSet) & `AER_SEC_IMPL;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] capCtlVal;
  always_comb begin
    capCtlVal = `AER_ZERO_RST;
    capCtlVal[`AER_CTL_BIT_CHKEN] = chkEn_r;
    capCtlVal[`AER_CTL_BIT_CHKCAP] = 1'b1;
    capCtlVal[`AER_CTL_BIT_GENEN] = genEn_r;
    capCtlVal[`AER_CTL_BIT_GENCAP] = 1'b1;
    capCtlVal[4:0] = firstErr_r;
  end

  logic [31:0] rdMux;
  always_comb begin
    unique case (cfgReq.addr)
      `AER_OFF_COR_STS: rdMux = corSts_r;
      `AER_OFF_COR_MSK: rdMux = corMsk_r;
      `AER_OFF_CAP_CTL: rdMux = capCtlVal;
      `AER_OFF_HDR0: rdMux = hdrLog_r[0];
      `AER_OFF_HDR1: rdMux = hdrLog_r[1];
      `AER_OFF_HDR2: rdMux = hdrLog_r[2];
      `AER_OFF_HDR3: rdMux = hdrLog_r[3];
      `AER_OFF_SEC_STS: rdMux = secSts_r;
      default: rdMux = `AER_ZERO_RST;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfgRdata <= `AER_ZERO_RST;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdata <= cfgReq.rd ? rdMux : `AER_ZERO_RST;
      cfgRdValid <= cfgReq.rd;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_tmout_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    corEvt.retransmitTimerExpired && !corMsk_r[12] && !softRst |=> corSts_r[12])
    else $error("timer expiry did not set status");
  a_roll_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    corEvt.retransmitCountWrap && !corMsk_r[8] && !softRst |=> corSts_r[8])
    else $error("count wrap did not set status");
  a_masked_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    corEvt == 5'h01 && corMsk_r[0] && !corSts_r[0] |=> !corSts_r[0] && !corErrMsg)
    else $error("masked error was reported");
  a_w1c_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    corSts_r[6] && !softRst && !(wrCorSts && cfgReq.wdata[6]) |=> corSts_r[6])
    else $error("status cleared without a one");
  a_rsv_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    (corSts_r[31:13] == 19'h0) && (secSts_r[8] == 1'b0) && (corMsk_r[5:1] == 5'h00))
    else $error("reserved bit nonzero");
  a_cap_ones: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfgReq.rd && cfgReq.addr == `AER_OFF_CAP_CTL |=> cfgRdata[7] && cfgRdata[5])
    else $error("capability bits not one");
  a_ptr_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
    ptrLoaded_r && !softRst |=> $stable(firstErr_r))
    else $error("first error pointer moved");
  a_serr_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    secEvt.pciSystemErrSeen && !softRst |=> secSts_r[12])
    else $error("system error not logged");
  a_chk_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrCapCtl && !softRst ##1 !softRst |=> e2eCrcCheckEnable == $past(cfgReq.wdata[8], 2))
    else $error("check enable did not follow write");
  a_soft_rst: assert property (@(posedge sys_clk) disable iff (!nrst)
    softRst |=> corMsk_r == 32'h0 && secSts_r == 32'h0 && hdrLog_r[0] == 32'h0)
    else $error("fields survived reset");
  a_lnk_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    corEvt.linkPacketSymbolErr && !corMsk_r[7] && !softRst |=> corSts_r[7])
    else $error("link packet symbol error not logged");
  a_tlp_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    corEvt.transactionPacketSymbolErr && !corMsk_r[6] && !softRst |=> corSts_r[6])
    else $error("transaction packet symbol error not logged");
  a_rxerr_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    corEvt.anySymbolErr && !corMsk_r[0] && !softRst |=> corSts_r[0])
    else $error("symbol error not logged");
  a_msk_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrCorMsk && !softRst |=> corMsk_r == ($past(cfgReq.wdata) & `AER_COR_IMPL))
    else $error("mask write not held");
  a_gen_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrCapCtl && !softRst ##1 !softRst |=> e2eCrcGenerateEnable == $past(cfgReq.wdata[6], 2))
    else $error("generate enable did not follow write");
  a_ptr_ro: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrCapCtl && !hdrCap.valid && !softRst |=> firstErr_r == $past(firstErr_r))
    else $error("first error pointer took a write");
  a_hdr_first: assert property (@(posedge sys_clk) disable iff (!nrst)
    hdrCap.valid && !softRst |=> hdrLog_r[0][7:0] == $past(hdrCap.header[127:120]))
    else $error("earliest header byte misplaced");
  a_hdr_last: assert property (@(posedge sys_clk) disable iff (!nrst)
    hdrCap.valid && !softRst |=> hdrLog_r[3][31:24] == $past(hdrCap.header[7:0]))
    else $error("last header byte misplaced");
  a_perr_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    secEvt.pciParityErrSeen && !softRst |=> secSts_r[11])
    else $error("parity error not logged");
  a_discard_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    secEvt.discardTimerExpired && !softRst |=> secSts_r[10])
    else $error("discard expiry not logged");
  a_addr_par: assert property (@(posedge sys_clk) disable iff (!nrst)
    secEvt.upstreamAddrParityErr && !softRst |=> secSts_r[9])
    else $error("address parity error not logged");
  a_data_par: assert property (@(posedge sys_clk) disable iff (!nrst)
    secEvt.upstreamDataParityErr && !softRst |=> secSts_r[7])
    else $error("data parity error not logged");
  a_mabort_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    secEvt.masterAbortRcvd && !softRst |=> secSts_r[3])
    else $error("master abort not logged");
  a_tabort_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
    secEvt.targetAbortRcvd && !softRst |=> secSts_r[2])
    else $error("target abort not logged");
  a_sec_w1c: assert property (@(posedge sys_clk) disable iff (!nrst)
    secSts_r[12] && !softRst && !(wrSecSts && cfgReq.wdata[12]) |=> secSts_r[12])
    else $error("secondary status cleared without a one");
  a_unmap_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfgReq.rd && (cfgReq.addr < `AER_OFF_COR_STS || cfgReq.addr > `AER_OFF_SEC_STS)
    |=> cfgRdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_cap_rsv: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfgReq.rd && cfgReq.addr == `AER_OFF_CAP_CTL |=> cfgRdata[31:9] == 23'h000000)
    else $error("control reserved bits nonzero");
endmodule

// ===== hw/aer_regs_consts.svh
// Offsets, field positions and reset values of the error reporting registers
`ifndef AER_REGS_CONSTS_SVH
`define AER_REGS_CONSTS_SVH
`define AER_OFF_COR_STS 12'h110
`define AER_OFF_COR_MSK 12'h114
`define AER_OFF_CAP_CTL 12'h118
`define AER_OFF_HDR0 12'h11C
`define AER_OFF_HDR1 12'h120
`define AER_OFF_HDR2 12'h124
`define AER_OFF_HDR3 12'h128
`define AER_OFF_SEC_STS 12'h12C
`define AER_COR_BIT_RXERR 0
`define AER_COR_BIT_BADTLP 6
`define AER_COR_BIT_BADLNK 7
`define AER_COR_BIT_ROLL 8
`define AER_COR_BIT_TMOUT 12
`define AER_COR_IMPL 32'h0000_11C1
`define AER_SEC_IMPL 32'h0000_1E8C
`define AER_CTL_BIT_CHKEN 8
`define AER_CTL_BIT_CHKCAP 7
`define AER_CTL_BIT_GENEN 6
`define AER_CTL_BIT_GENCAP 5
`define AER_CAP_CTL_RST 32'h0000_00A0
`define AER_ZERO_RST 32'h0000_0000
`define AER_PTR_RST 5'h00
`endif

// ===== hw/aer_regs_pkg.sv
// Types shared by the error reporting register bank
package aer_regs_pkg;
  // Correctable events from the link and physical layer
  typedef struct packed {
    logic retransmitTimerExpired;
    logic retransmitCountWrap;
    logic linkPacketSymbolErr;
    logic transactionPacketSymbolErr;
    logic anySymbolErr;
  } aer_cor_evt_s;
  // Events seen on the secondary PCI bus
  typedef struct packed {
    logic pciSystemErrSeen;
    logic pciParityErrSeen;
    logic discardTimerExpired;
    logic upstreamAddrParityErr;
    logic upstreamDataParityErr;
    logic masterAbortRcvd;
    logic targetAbortRcvd;
  } aer_sec_evt_s;
  // Config access from the link side
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } aer_cfg_req_s;
  // Header capture for an uncorrectable error
  typedef struct packed {
    logic valid;
    logic [4:0] statusBit;
    logic [127:0] header;
  } aer_hdr_cap_s;
endpackage

// ===== verif/aer_event_src.sv
// Event source standing in for the link, physical layer and PCI side detectors
`timescale 1ns/100ps
module aer_event_src
  import aer_regs_pkg::*;
(
  input wire logic sys_clk,
  output aer_cor_evt_s corEvt,
  output aer_sec_evt_s secEvt,
  output aer_hdr_cap_s hdrCap
);
  initial begin
    corEvt = '0;
    secEvt = '0;
    hdrCap = '0;
  end
  // ------------------------------------------------------------
  // One-cycle detector pulses
  // ------------------------------------------------------------
  task automatic cor(input aer_cor_evt_s e);
    @(posedge sys_clk);
    corEvt <= e;
    @(posedge sys_clk);
    corEvt <= '0;
  endtask
  task automatic sec(input aer_sec_evt_s e);
    @(posedge sys_clk);
    secEvt <= e;
    @(posedge sys_clk);
    secEvt <= '0;
  endtask
  task automatic hdr(input logic [4:0] p, input logic [127:0] h);
    @(posedge sys_clk);
    hdrCap <= {1'b1, p, h};
    @(posedge sys_clk);
    // Payload goes stale once valid drops, so a late sample shows
    hdrCap <= {1'b0, ~p, ~h};
  endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking testbench for the error reporting register bank
`timescale 1ns/100ps
`include "aer_regs_consts.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb_top
  import aer_regs_pkg::*;
;
  logic sys_clk, nrst, globalResetPin, fundamentalReset;
  aer_cfg_req_s cfgReq;
  logic [31:0] cfgRdata;
  logic cfgRdValid, corErrMsg, e2eCrcCheckEnable, e2eCrcGenerateEnable;
  aer_cor_evt_s corEvt;
  aer_sec_evt_s secEvt;
  aer_hdr_cap_s hdrCap;
  int fails, compares;
  logic [11:0] offs [10] = '{`AER_OFF_COR_STS, `AER_OFF_COR_MSK, `AER_OFF_CAP_CTL,
    `AER_OFF_HDR0, `AER_OFF_HDR1, `AER_OFF_HDR2, `AER_OFF_HDR3, `AER_OFF_SEC_STS,
    12'h100, 12'h130};
  logic [31:0] corBit [5] = '{32'h1, 32'h40, 32'h80, 32'h100, 32'h1000};
  logic [31:0] secBit [7] = '{32'h4, 32'h8, 32'h80, 32'h200, 32'h400, 32'h800, 32'h1000};

  aer_regs u_dut (.sys_clk(sys_clk), .nrst(nrst), .globalResetPin(globalResetPin),
    .fundamentalReset(fundamentalReset), .cfgReq(cfgReq), .cfgRdata(cfgRdata),
    .cfgRdValid(cfgRdValid), .corEvt(corEvt), .secEvt(secEvt), .hdrCap(hdrCap),
    .corErrMsg(corErrMsg), .e2eCrcCheckEnable(e2eCrcCheckEnable),
    .e2eCrcGenerateEnable(e2eCrcGenerateEnable));
  aer_event_src u_src (.sys_clk(sys_clk), .corEvt(corEvt), .secEvt(secEvt), .hdrCap(hdrCap));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ------------------------------------------------------------
  // Config access tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cfgReq <= {1'b0, 1'b1, a, d};
    @(posedge sys_clk);
    cfgReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    @(posedge sys_clk);
    cfgReq <= {1'b1, 1'b0, a, 32'h0000_0000};
    @(posedge sys_clk);
    cfgReq.rd <= 1'b0;
    #1;
    `CHK("rdValid", 1'b1, cfgRdValid)
    `CHK("rdata", ex, cfgRdata)
  endtask
  task automatic chkDefaults();
    foreach (offs[i])
      rd(offs[i], (offs[i] == `AER_OFF_CAP_CTL) ? `AER_CAP_CTL_RST : `AER_ZERO_RST);
  endtask
  task automatic hdrCase(input logic [4:0] p, input logic [7:0] b0, input logic [4:0] ptrEx);
    logic [127:0] h;
    for (int k = 0; k < 16; k++)
      h[127-8*k -: 8] = b0 + 8'(k);
    u_src.hdr(p, h);
    for (int i = 0; i < 4; i++)
      rd(`AER_OFF_HDR0 + 12'(4*i),
        {b0 + 8'(4*i+3), b0 + 8'(4*i+2), b0 + 8'(4*i+1), b0 + 8'(4*i)});
    rd(`AER_OFF_CAP_CTL, 32'h0000_00E0 | 32'(ptrEx));
  endtask
  task automatic pinReset(input int which);
    u_src.sec(aer_sec_evt_s'(7'h7F));
    wr(`AER_OFF_CAP_CTL, 32'h0000_0140);
    if (which == 0)
      globalResetPin <= 1'b1;
    else
      fundamentalReset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wr(`AER_OFF_COR_MSK, 32'h0000_0001);
    globalResetPin <= 1'b0;
    fundamentalReset <= 1'b0;
    #1;
    `CHK("chkEnRst", 1'b0, e2eCrcCheckEnable)
    repeat (4) @(posedge sys_clk);
    chkDefaults();
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    globalResetPin = 1'b0;
    fundamentalReset = 1'b0;
    cfgReq = '0;
    fails = 0;
    compares = 0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    chkDefaults();
    wr(`AER_OFF_COR_MSK, 32'hFFFF_FFFF);
    rd(`AER_OFF_COR_MSK, `AER_COR_IMPL);
    for (int i = 0; i < 5; i++) begin
      u_src.cor(aer_cor_evt_s'(5'h01 << i));
      #1 `CHK("corMsgMasked", 1'b0, corErrMsg)
    end
    rd(`AER_OFF_COR_STS, 32'h0000_0000);
    wr(`AER_OFF_COR_MSK, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      u_src.cor(aer_cor_evt_s'(5'h01 << i));
      #1 `CHK("corMsg", 1'b1, corErrMsg)
      rd(`AER_OFF_COR_STS, corBit[i]);
      wr(`AER_OFF_COR_STS, ~corBit[i]);
      rd(`AER_OFF_COR_STS, corBit[i]);
      wr(`AER_OFF_COR_STS, 32'hFFFF_FFFF);
      rd(`AER_OFF_COR_STS, 32'h0000_0000);
    end
    for (int i = 0; i < 7; i++) begin
      u_src.sec(aer_sec_evt_s'(7'h01 << i));
      rd(`AER_OFF_SEC_STS, secBit[i]);
      wr(`AER_OFF_SEC_STS, ~secBit[i]);
      rd(`AER_OFF_SEC_STS, secBit[i]);
      wr(`AER_OFF_SEC_STS, 32'hFFFF_FFFF);
      rd(`AER_OFF_SEC_STS, 32'h0000_0000);
    end
    // Event and clear in one cycle: set wins
    fork
      u_src.cor(aer_cor_evt_s'(5'h01));
      wr(`AER_OFF_COR_STS, 32'h0000_0001);
    join
    rd(`AER_OFF_COR_STS, 32'h0000_0001);
    wr(`AER_OFF_COR_STS, 32'h0000_0001);
    rd(`AER_OFF_COR_STS, 32'h0000_0000);
    wr(`AER_OFF_CAP_CTL, 32'hFFFF_FFFF);
    rd(`AER_OFF_CAP_CTL, 32'h0000_01E0);
    wr(`AER_OFF_CAP_CTL, 32'h0000_0100);
    @(posedge sys_clk);
    #1 `CHK("chkEn", 1'b1, e2eCrcCheckEnable)
    `CHK("genEn", 1'b0, e2eCrcGenerateEnable)
    wr(`AER_OFF_CAP_CTL, 32'h0000_005F);
    @(posedge sys_clk);
    #1 `CHK("chkEn", 1'b0, e2eCrcCheckEnable)
    `CHK("genEn", 1'b1, e2eCrcGenerateEnable)
    rd(`AER_OFF_CAP_CTL, 32'h0000_00E0);
    hdrCase(5'h04, 8'h00, 5'h04);
    hdrCase(5'h12, 8'h80, 5'h04);
    wr(`AER_OFF_HDR0, 32'hFFFF_FFFF);
    rd(`AER_OFF_HDR0, 32'h8382_8180);
    pinReset(0);
    pinReset(1);
    final_report();
  end
  initial begin
    #(20000 * 4);
    fails++;
    final_report();
  end
endmodule
